// ==== hdl/brake_interlock_sequencer.sv ====
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module brake_interlock_sequencer #(
	parameter int MS_CYCLES = brake_pkg::MS_CYCLES_DEF
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [brake_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins, asynchronous
	input wire logic servoOnPin,
	input wire logic alarmResetPin,
	// drive control side
	input wire brake_pkg::drive_in_t drive,
	input wire brake_pkg::alarm_src_t alarmSrc,
	// general_io_connector output and drive status
	output logic brakeReleaseOutput,
	output logic motorPower,
	output logic [brake_pkg::SEL_W-1:0] dynBrakeMode,
	output logic servoOnState,
	output logic alarmActive,
	output logic irq
);
	import brake_pkg::*;
	localparam int TW = $clog2(MS_CYCLES + 1);
	function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction : regHit
	seq_state_t state_r, state_nxt;
	logic [1:0] pinMeta_r, pinSync_r;
	logic servoOnPrev_r;
	logic [TW-1:0] tickCnt_r;
	logic [DLY_W-1:0] dlyCnt_r;
	logic [SEL_W-1:0] ctrl_r;
	logic [DLY_W-1:0] stopDly_r, runDly_r, rstTime_r;
	logic [SPD_W-1:0] clrSpd_r;
	logic [INT_W-1:0] intStat_r, intEn_r, intStat_nxt, evt, clrMask;
	logic [CAUSE_W-1:0] cause_r, cause_nxt;
	logic needFresh_r, wasRunning_r;
	logic brake_r, brake_nxt, power_r, onState_r, alarm_r, irq_r, dynSelAct;
	logic [SEL_W-1:0] dynMode_r;
	logic [31:0] prdata_r, rdMux, statusWord;
	logic pready_r, pslverr_r;
	logic servoOnLvl, rstAccept, alarmNow, okSpeedStop, okSpeedClr, goOn;
	logic tickWrap, stateChg, stopDone, runDone, powered, servoOnRise;
	logic apbAccess, apbDone, wrEn, mapped;
	logic selCtrl, selStop, selRun, selClr, selRst, selStat, selIStat, selIClr, selIEn;
	assign servoOnLvl = pinSync_r[0];
	assign servoOnRise = servoOnLvl && !servoOnPrev_r;
	alarm_reset_filter #(.MS_CYCLES(MS_CYCLES)) resetFilter (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.levelIn(pinSync_r[1]),
		.holdMs(rstTime_r),
		.accept(rstAccept)
	);
	assign alarmNow = |alarmSrc;
	assign okSpeedStop = drive.speed <= STOP_SPEED_RPM;
	assign okSpeedClr = drive.speed <= clrSpd_r;
	assign goOn = servoOnLvl && !needFresh_r && okSpeedStop && (!wasRunning_r || okSpeedClr)
		&& !alarmNow;
	assign tickWrap = tickCnt_r == TW'(MS_CYCLES - 1);
	assign stopDone = dlyCnt_r >= stopDly_r;
	assign runDone = (dlyCnt_r >= runDly_r) || okSpeedClr;
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF:
				if (alarmNow)
					state_nxt = ST_ALARM;
				else if (goOn)
					state_nxt = ST_ON;
			ST_ON:
				if (alarmNow || (!servoOnLvl && !okSpeedStop))
					state_nxt = ST_RUN_DLY;
				else if (!servoOnLvl)
					state_nxt = ST_STOP_DLY;
			ST_STOP_DLY:
				if (alarmNow)
					state_nxt = ST_RUN_DLY;
				else if (stopDone)
					state_nxt = ST_OFF;
			ST_RUN_DLY:
				if (runDone)
					state_nxt = (|cause_r || alarmNow) ? ST_ALARM : ST_OFF;
			ST_ALARM:
				if (rstAccept)
					state_nxt = ST_OFF;
			default:
				state_nxt = ST_OFF;
		endcase
	end

	assign stateChg = state_nxt != state_r;
	assign powered = (state_nxt == ST_ON) || (state_nxt == ST_STOP_DLY)
		|| (state_nxt == ST_RUN_DLY);
	// hold release during delays, follow the release request
	assign brake_nxt = ((state_nxt == ST_ON) && drive.releaseReq)
		|| ((state_nxt == ST_STOP_DLY || state_nxt == ST_RUN_DLY) && brake_r);
	// dynamic brake selection whenever not servo on
	assign dynSelAct = state_nxt != ST_ON;
	assign cause_nxt = rstAccept ? alarmSrc : (cause_r | alarmSrc);
	// delays are exact: the ms prescaler restarts with each state
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= ST_OFF;
			tickCnt_r <= '0;
			pinMeta_r <= '0;
			pinSync_r <= '0;
			dlyCnt_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			// two flops on both pins before anything looks at them
			pinMeta_r <= {alarmResetPin, servoOnPin};
			pinSync_r <= pinMeta_r;
			tickCnt_r <= (stateChg || tickWrap) ? '0 : tickCnt_r + 1'b1;
			if (stateChg)
				dlyCnt_r <= '0;
			else if (tickWrap && dlyCnt_r != '1)
				dlyCnt_r <= dlyCnt_r + 1'b1;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			brake_r <= 1'b0;
			power_r <= 1'b0;
			onState_r <= 1'b0;
			dynMode_r <= '0;
			alarm_r <= 1'b0;
			cause_r <= '0;
			servoOnPrev_r <= 1'b0;
			needFresh_r <= 1'b0;
			wasRunning_r <= 1'b0;
		end
		else
		begin
			brake_r <= brake_nxt;
			power_r <= powered;
			onState_r <= state_nxt == ST_ON;
			dynMode_r <= dynSelAct ? ctrl_r : '0;
			alarm_r <= |cause_nxt;
			cause_r <= cause_nxt;
			servoOnPrev_r <= servoOnLvl;
			// fresh servo-on after reset, remember running stop
			needFresh_r <= rstAccept || (needFresh_r && servoOnLvl);
			if (state_nxt == ST_RUN_DLY)
				wasRunning_r <= 1'b1;
			else if (state_nxt == ST_ON)
				wasRunning_r <= 1'b0;
		end
	end
	// apb decode
	assign apbAccess = psel && penable;
	assign apbDone = apbAccess && pready_r;
	assign wrEn = apbDone && pwrite;
	assign selCtrl = regHit(paddr, OFF_CTRL);
	assign selStop = regHit(paddr, OFF_STOP_DLY);
	assign selRun = regHit(paddr, OFF_RUN_DLY);
	assign selClr = regHit(paddr, OFF_CLR_SPD);
	assign selRst = regHit(paddr, OFF_RST_TIME);
	assign selStat = regHit(paddr, OFF_STATUS);
	assign selIStat = regHit(paddr, OFF_INT_STAT);
	assign selIClr = regHit(paddr, OFF_INT_CLR);
	assign selIEn = regHit(paddr, OFF_INT_EN);
	assign mapped = selCtrl | selStop | selRun | selClr | selRst | selStat | selIStat
		| selIClr | selIEn;
	always_comb
	begin
		statusWord = '0;
		statusWord[STAT_BRAKE] = brake_r;
		statusWord[STAT_POWER] = power_r;
		statusWord[STAT_ON] = onState_r;
		statusWord[STAT_FRESH] = needFresh_r;
		statusWord[STAT_RUNWAS] = wasRunning_r;
		statusWord[STAT_ALARM] = state_r == ST_ALARM;
		statusWord[STAT_CAUSE +: CAUSE_W] = cause_r;
	end

	assign rdMux = selCtrl ? {{(32 - SEL_W){1'b0}}, ctrl_r}
		: selStop ? {16'h0000, stopDly_r}
		: selRun ? {16'h0000, runDly_r}
		: selClr ? {16'h0000, clrSpd_r}
		: selRst ? {16'h0000, rstTime_r}
		: selStat ? statusWord
		: selIStat ? {{(32 - INT_W){1'b0}}, intStat_r}
		: selIEn ? {{(32 - INT_W){1'b0}}, intEn_r}
		: 32'h00000000;
	// one wait state: data and error are registered on the same edge that raises pready
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
			intStat_r <= '0;
			irq_r <= 1'b0;
		end
		else
		begin
			pready_r <= apbAccess && !pready_r;
			pslverr_r <= apbAccess && !pready_r && !mapped;
			if (apbAccess && !pready_r)
				prdata_r <= pwrite ? 32'h00000000 : rdMux;
			intStat_r <= intStat_nxt;
			irq_r <= |(intStat_nxt & intEn_r);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_r <= STOP_SEL_DEF;
			stopDly_r <= STOP_DLY_DEF;
			runDly_r <= RUN_DLY_DEF;
			clrSpd_r <= CLR_SPEED_DEF;
			rstTime_r <= RST_TIME_DEF;
			intEn_r <= '0;
		end
		else if (wrEn)
		begin
			if (selCtrl)
				ctrl_r <= pwdata[SEL_W-1:0];
			if (selStop)
				stopDly_r <= pwdata[DLY_W-1:0];
			if (selRun)
				runDly_r <= pwdata[DLY_W-1:0];
			if (selClr)
				clrSpd_r <= pwdata[SPD_W-1:0];
			if (selRst)
				rstTime_r <= pwdata[DLY_W-1:0];
			if (selIEn)
				intEn_r <= pwdata[INT_W-1:0];
		end
	end
	// events; a set in the clearing cycle wins
	always_comb
	begin
		evt = '0;
		evt[INT_BRAKE] = brake_r && !brake_nxt;
		evt[INT_ALARM] = (state_nxt == ST_ALARM) && (state_r != ST_ALARM);
		evt[INT_RESET] = rstAccept;
		evt[INT_HELD] = servoOnRise && (state_r == ST_OFF) && !goOn;
	end
	assign clrMask = (wrEn && selIClr) ? pwdata[INT_W-1:0] : '0;
	assign intStat_nxt = evt | (intStat_r & ~clrMask);
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign brakeReleaseOutput = brake_r;
	assign motorPower = power_r;
	assign dynBrakeMode = dynMode_r;
	assign servoOnState = onState_r;
	assign alarmActive = alarm_r;
	assign irq = irq_r;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	stop_hold_a:
	assert property ((state_r == ST_STOP_DLY && !stopDone && !alarmNow)
		|=> (state_r == ST_STOP_DLY) && brake_r == $past(brake_r))
	else $error("stopped delay lost the brake release");
	stop_end_a:
	assert property ((state_r == ST_STOP_DLY && stopDone && !alarmNow)
		|=> !brake_r && !power_r && state_r == ST_OFF)
	else $error("stopped delay did not end");
	run_speed_a:
	assert property ((state_r == ST_RUN_DLY && okSpeedClr) |=> !brake_r && !power_r)
	else $error("clear speed did not end running delay");
	run_time_a:
	assert property ((state_r == ST_RUN_DLY && dlyCnt_r >= runDly_r)
		|=> state_r != ST_RUN_DLY && !brakeReleaseOutput)
	else $error("running delay overran");
	on_speed_a:
	assert property ($rose(onState_r) |-> $past(drive.speed) <= STOP_SPEED_RPM)
	else $error("servo on above stop speed");
	on_running_a:
	assert property ((state_r == ST_OFF && wasRunning_r && !okSpeedClr) |=> state_r != ST_ON)
	else $error("servo on above clear speed");
	release_req_a:
	assert property ((state_r == ST_ON) |-> brakeReleaseOutput == $past(drive.releaseReq))
	else $error("release output differs from request");
	boot_brake_a:
	assert property ($rose(brake_r) |-> $past(drive.releaseReq))
	else $error("brake released without request");
	alarm_seq_a:
	assert property ((state_r == ST_ON && alarmNow) |=> state_r == ST_RUN_DLY ##1 alarm_r)
	else $error("alarm did not start running timing");
	fresh_on_a:
	assert property ((state_r == ST_ALARM && rstAccept)
		|=> state_r == ST_OFF && needFresh_r && !power_r)
	else $error("alarm reset did not leave servo off");
	dyn_sel_a:
	assert property ((state_r != ST_ON) |-> dynMode_r == $past(ctrl_r))
	else $error("dynamic brake mode not from selection");
endmodule : brake_interlock_sequencer

// ==== shared/brake_pkg.sv ====
package brake_pkg;
	localparam int CLK_MHZ = 200;
	localparam int MS_US = 1000;
	localparam int MS_CYCLES_DEF = CLK_MHZ * MS_US;
	localparam int SPD_W = 16;
	localparam int DLY_W = 16;
	localparam int SEL_W = 4;
	localparam int INT_W = 4;
	localparam int ADDR_W = 8;
	localparam logic [SPD_W-1:0] STOP_SPEED_RPM = 16'h001e;
	localparam logic [DLY_W-1:0] RST_TIME_DEF = 16'h0078;
	localparam logic [DLY_W-1:0] STOP_DLY_DEF = 16'h0000;
	localparam logic [DLY_W-1:0] RUN_DLY_DEF = 16'h0032;
	localparam logic [SPD_W-1:0] CLR_SPEED_DEF = 16'h001e;
	localparam logic [SEL_W-1:0] STOP_SEL_DEF = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STOP_DLY = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RUN_DLY = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CLR_SPD = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_RST_TIME = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h20;
	localparam int STAT_BRAKE = 0;
	localparam int STAT_POWER = 1;
	localparam int STAT_ON = 2;
	localparam int STAT_FRESH = 3;
	localparam int STAT_RUNWAS = 4;
	localparam int STAT_ALARM = 5;
	localparam int STAT_CAUSE = 8;
	localparam int INT_BRAKE = 0;
	localparam int INT_ALARM = 1;
	localparam int INT_RESET = 2;
	localparam int INT_HELD = 3;
	typedef enum {ST_OFF, ST_ON, ST_STOP_DLY, ST_RUN_DLY, ST_ALARM} seq_state_t;
	typedef struct packed {
		logic [SPD_W-1:0] speed;
		logic releaseReq;
	} drive_in_t;
	typedef struct packed {
		logic ext;
		logic phaseLoss;
		logic underVolt;
	} alarm_src_t;
	localparam int CAUSE_W = $bits(alarm_src_t);
endpackage : brake_pkg

// ==== hdl/alarm_reset_filter.sv ====
`timescale 1ns/1ps
module alarm_reset_filter #(
	parameter int MS_CYCLES = brake_pkg::MS_CYCLES_DEF
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// synchronised level and its hold time in ms
	input wire logic levelIn,
	input wire logic [brake_pkg::DLY_W-1:0] holdMs,
	// one pulse per accepted assertion
	output logic accept
);
	import brake_pkg::*;
	localparam int SW = $clog2(MS_CYCLES + 1);
	logic [SW-1:0] subCnt_r;
	logic [DLY_W-1:0] msCnt_r;
	logic done_r;
	logic accept_r;
	logic msWrap;
	logic reached;
	assign msWrap = subCnt_r == SW'(MS_CYCLES - 1);
	assign reached = levelIn && !done_r && (msCnt_r >= holdMs);
	assign accept = accept_r;
	// a release restarts the count, so chatter never adds up to a reset
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			subCnt_r <= '0;
			msCnt_r <= '0;
			done_r <= 1'b0;
			accept_r <= 1'b0;
		end
		else if (!levelIn)
		begin
			subCnt_r <= '0;
			msCnt_r <= '0;
			done_r <= 1'b0;
			accept_r <= 1'b0;
		end
		else
		begin
			accept_r <= reached;
			done_r <= done_r | reached;
			subCnt_r <= msWrap ? '0 : subCnt_r + 1'b1;
			if (msWrap && msCnt_r != '1)
				msCnt_r <= msCnt_r + 1'b1;
		end
	end
	hold_time_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		accept_r |-> $past(levelIn) && ($past(msCnt_r) >= $past(holdMs)))
	else $error("alarm reset accepted before hold time");
endmodule : alarm_reset_filter

// ==== bench/motor_model.sv ====
`timescale 1ns/1ps
module motor_model
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// drive outputs seen by the motor
	input wire logic motorPower,
	input wire logic brakeReleaseOutput,
	// speed the load settles at while powered with the brake released
	input wire logic [brake_pkg::SPD_W-1:0] targetSpeed,
	output logic [brake_pkg::SPD_W-1:0] speed_r
);
	import brake_pkg::*;
	logic [SPD_W-1:0] speed_nxt;
	// an engaged brake holds a powered shaft; unpowered it only coasts down, wear not modelled
	assign speed_nxt = ((motorPower && brakeReleaseOutput) || targetSpeed < speed_r)
		? targetSpeed : speed_r;
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			speed_r <= '0;
		else
			speed_r <= speed_nxt;
endmodule : motor_model

// ==== bench/brake_interlock_sequencer_bench.sv ====
`timescale 1ns/1ps
module brake_interlock_sequencer_bench;
	import brake_pkg::*;
	localparam int MSC = 10;
	logic mclk;
	logic sys_rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic servoOnPin;
	logic alarmResetPin;
	logic relReq;
	logic [SPD_W-1:0] target;
	logic [SPD_W-1:0] motorSpeed;
	drive_in_t drive;
	alarm_src_t alarmSrc;
	logic brakeOut;
	logic motorPower;
	logic [SEL_W-1:0] dynBrakeMode;
	logic servoOnState;
	logic alarmActive;
	logic irq;
	int fails;
	int total_checks;
	int seed;
	int n;
	logic [31:0] rd;
	logic err;
	logic [SEL_W-1:0] sel;
	logic [SPD_W-1:0] clr;
	logic [SPD_W-1:0] fast;
	assign drive = {motorSpeed, relReq};
	brake_interlock_sequencer #(.MS_CYCLES(MSC)) DUT (.mclk(mclk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .servoOnPin(servoOnPin),
		.alarmResetPin(alarmResetPin), .drive(drive), .alarmSrc(alarmSrc),
		.brakeReleaseOutput(brakeOut), .motorPower(motorPower), .dynBrakeMode(dynBrakeMode),
		.servoOnState(servoOnState), .alarmActive(alarmActive), .irq(irq));
	motor_model load (.mclk(mclk), .sys_rst(sys_rst), .motorPower(motorPower),
		.brakeReleaseOutput(brakeOut), .targetSpeed(target), .speed_r(motorSpeed));
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task complete_run;
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : check
	function automatic int cyc(input int ms);
		return ms * MSC;
	endfunction : cyc
	function automatic logic [SEL_W-1:0] exp_mode(input logic on);
		return on ? '0 : sel;
	endfunction : exp_mode
	function automatic logic pick(input int which);
		case (which)
			0: return brakeOut;
			1: return servoOnState;
			2: return alarmActive;
			default: return irq;
		endcase
	endfunction : pick
	// bounded wait on one output, n holds the cycles spent
	task wait_for(input int which, input logic val, input int lim);
		n = 0;
		while (pick(which) !== val && n < lim)
		begin
			@(posedge mclk);
			n++;
		end
		check(pick(which), val, "wait ran out");
		if (pick(which) !== val)
			complete_run;
	endtask : wait_for
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge mclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(pready, 1'b1, "no apb answer");
		if (pready !== 1'b1)
			complete_run;
	endtask : apb
	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
		apb(1'b0, a, 32'h0);
		check(rd, exp, "register read");
		check(err, expErr, "slave error");
	endtask : rd_chk
	initial
	begin
		seed = 3807;
		fails = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		servoOnPin = 1'b0;
		alarmResetPin = 1'b0;
		relReq = 1'b0;
		target = '0;
		alarmSrc = '0;
		sel = 4'($random(seed)) | 4'h1;
		clr = 16'(5 + $unsigned($random(seed)) % 21);
		fast = 16'(100 + $unsigned($random(seed)) % 900);
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		check({brakeOut, motorPower, servoOnState, irq}, 32'h0, "outputs after reset");
		rd_chk(OFF_CTRL, 32'h0, 1'b0);
		rd_chk(OFF_RUN_DLY, 32'h32, 1'b0);
		rd_chk(OFF_CLR_SPD, 32'h1e, 1'b0);
		rd_chk(OFF_RST_TIME, 32'h78, 1'b0);
		rd_chk(OFF_INT_EN, 32'h0, 1'b0);
		rd_chk(8'h40, 32'h0, 1'b1);
		apb(1'b1, OFF_CTRL, {28'h0, sel});
		apb(1'b1, OFF_STOP_DLY, 32'h3);
		apb(1'b1, OFF_RUN_DLY, 32'h5);
		apb(1'b1, OFF_CLR_SPD, {16'h0, clr});
		apb(1'b1, OFF_RST_TIME, 32'h2);
		apb(1'b1, OFF_INT_EN, 32'hf);
		servoOnPin <= 1'b1;
		wait_for(1, 1'b1, 10);
		repeat (3) @(posedge mclk);
		check(dynBrakeMode, exp_mode(1'b1), "mode while on");
		check(brakeOut, 1'b0, "release without request");
		relReq <= 1'b1;
		wait_for(0, 1'b1, 3);
		servoOnPin <= 1'b0;
		wait_for(1, 1'b0, 6);
		wait_for(0, 1'b0, cyc(3) + 3);
		check(32'(n >= cyc(3) - 2), 32'h1, "stopped brake early");
		check(motorPower, 1'b0, "power after stop");
		check(dynBrakeMode, exp_mode(1'b0), "mode while off");
		servoOnPin <= 1'b1;
		wait_for(1, 1'b1, 10);
		target <= fast;
		repeat (3) @(posedge mclk);
		servoOnPin <= 1'b0;
		wait_for(1, 1'b0, 6);
		wait_for(0, 1'b0, cyc(5) + 3);
		check(32'(n >= cyc(5) - 2), 32'h1, "running brake early");
		check(motorPower, 1'b0, "power after run stop");
		// still coasting fast, a new command must wait
		servoOnPin <= 1'b1;
		repeat (40) @(posedge mclk);
		check(servoOnState, 1'b0, "on while coasting");
		target <= clr + 16'h1;
		repeat (40) @(posedge mclk);
		check(servoOnState, 1'b0, "on above clear speed");
		target <= clr;
		wait_for(1, 1'b1, 10);
		target <= fast;
		repeat (3) @(posedge mclk);
		alarmSrc <= 3'h2;
		wait_for(2, 1'b1, 3);
		repeat (10) @(posedge mclk);
		check(brakeOut, 1'b1, "alarm brake early");
		target <= clr;
		wait_for(0, 1'b0, 4);
		check(motorPower, 1'b0, "power in alarm");
		apb(1'b0, OFF_INT_STAT, 32'h0);
		check(rd[INT_ALARM], 1'b1, "alarm event");
		check(rd[INT_HELD], 1'b1, "refused servo-on event");
		check(rd[INT_BRAKE], 1'b1, "brake engaged event");
		apb(1'b1, OFF_INT_CLR, 32'hf);
		wait_for(3, 1'b0, 4);
		alarmSrc <= '0;
		target <= '0;
		// too short a press is ignored
		alarmResetPin <= 1'b1;
		repeat (10) @(posedge mclk);
		alarmResetPin <= 1'b0;
		repeat (30) @(posedge mclk);
		check(alarmActive, 1'b1, "short reset taken");
		alarmResetPin <= 1'b1;
		wait_for(2, 1'b0, cyc(2) + 8);
		check(32'(n >= cyc(2)), 32'h1, "reset taken early");
		alarmResetPin <= 1'b0;
		repeat (20) @(posedge mclk);
		check(servoOnState, 1'b0, "on without fresh command");
		rd_chk(OFF_STATUS, 32'h18, 1'b0);
		check(irq, 1'b1, "irq not raised");
		apb(1'b1, OFF_INT_EN, 32'h0);
		repeat (3) @(posedge mclk);
		check(irq, 1'b0, "irq not masked");
		apb(1'b0, OFF_INT_STAT, 32'h0);
		check(rd[INT_RESET], 1'b1, "reset event");
		servoOnPin <= 1'b0;
		repeat (5) @(posedge mclk);
		servoOnPin <= 1'b1;
		wait_for(1, 1'b1, 10);
		complete_run;
	end
endmodule : brake_interlock_sequencer_bench
